// file: core/pcc_regs.svh
// register offsets, field positions, reset values and card information length and top address
`ifndef PCC_REGS_SVH
`define PCC_REGS_SVH
`define PCC_ADDR_CCS        11'h0202
`define PCC_ADDR_RCT        11'h0204
`define PCC_ADDR_CCN        11'h0206
`define PCC_CCS_RESET       8'h00
`define PCC_RCT_RESET       8'h0c
`define PCC_CCN_RESET       8'h00
`define PCC_RCT_FIXED_ONES  8'h0c
`define PCC_BIT_CHANGE_DETECTED_FLAG       7
`define PCC_BIT_SIGEN       6
`define PCC_BIT_IO8         5
`define PCC_BIT_PDREQ       2
`define PCC_BIT_INTERRUPT_REQUEST_STATUS        1
`define PCC_BIT_CRL         5
`define PCC_BIT_RDY         1
`define PCC_BIT_DRV         4
`define PCC_CIS_LEN         22
`define PCC_CIS_TOP         11'h002a
`define PCC_SLEEP_NS        100
`define PCC_CLK_NS          5
`define PCC_SLEEP_CYC       ((`PCC_SLEEP_NS + `PCC_CLK_NS - 1) / `PCC_CLK_NS)
`define PCC_IDLE_CYC        4000
`endif

// file: core/pcc_pkg.sv
// types for the card configuration and status register bank
package pcc_pkg;
    typedef enum logic [1:0] {
        PCC_ACTIVE   = 2'b00,
        PCC_TO_SLEEP = 2'b01,
        PCC_SLEEP    = 2'b11,
        PCC_TO_WAKE  = 2'b10
    } pcc_pwr_t;

    typedef struct packed {
        logic [1:0]  rst_sync;
        logic [2:0]  oe_s;
        logic [2:0]  we_s;
        logic        sig_en;
        logic        io8;
        logic        pd_req;
        logic        crl;
        logic        crl_mask;
        logic        drv;
        pcc_pwr_t    pwr;
        logic [11:0] cnt;
        logic [11:0] idle_cnt;
        logic        ready;
        logic        ready_q;
        logic        stschg_n;
        logic [7:0]  rdata;
        logic        rdata_oe;
        logic        irq_q;
        logic        auto_sleep;
        logic        sleep;
    } pcc_state_t;
endpackage : pcc_pkg

// file: core/pcc_config_status.sv
// card configuration, status, ready tracking and card information structure
`timescale 1ns/1ps
`default_nettype none
`include "pcc_regs.svh"

// Overview of operation
// - change flag reads one while latch set
// - status change low: flag, enable, I/O
// - status change high when enable clear
// - power-down bit selects sleep or active
// - ready shows busy until state reached
// - auto sleep when idle, wake on command
// - interrupt mirror bit, set until serviced
// - interrupt bit zero when interrupts disabled
// - latch sets on ready change, host-writable
// - ready read is pin; write masks latch
// - drive bit held and readable, other bits read zero
// - information structure at even attribute addresses
// - tuple: code, link, body, end marker
// - other-conditions tuple: 3V, 250ns, 2k
// - JEDEC tuple with two identification bytes
// - maker tuple: maker and product codes
// - registers unreachable in IDE mode
module pcc_config_status #(
    parameter logic [7:0]  JEDEC_MAKER  = 8'h5a, // arbitrary value
    parameter logic [7:0]  JEDEC_DEVICE = 8'h3c, // arbitrary value
    parameter logic [15:0] MAKER_CODE   = 16'h0a5a, // arbitrary value
    parameter logic [15:0] PRODUCT_CODE = 16'h0c3c, // arbitrary value
    parameter int          IDLE_CYC     = `PCC_IDLE_CYC
) (
    input  wire logic        clk,        // 200 MHz clock
    input  wire logic        rst_n,      // async reset, active low
    input  wire logic        ce,         // clock enable
    input  wire logic        reg_n,      // attribute select, active low
    input  wire logic        ce1_n,      // even byte select, active low
    input  wire logic        oe_n,       // read strobe, active low
    input  wire logic        we_n,       // write strobe, active low
    input  wire logic [10:0] addr,       // attribute address
    input  wire logic [7:0]  wdata,      // write data
    input  wire logic        ide_mode,   // card in IDE-compatible mode
    input  wire logic        io_mode,    // card configured for I/O
    input  wire logic        irq_int,    // internal interrupt request
    input  wire logic        irq_dis,    // interrupt-disable from device control
    input  wire logic        cmd_strobe, // command received pulse
    input  wire logic        core_busy,  // command engine busy
    output logic [7:0]       rdata,      // read data
    output logic             rdata_oe,   // read data drive enable
    output logic             stschg_n,   // status change, active low
    output logic             ready,      // ready pin
    output logic             sleep,      // power-down state reached
    output logic             eight_bit_host_flag // narrow host flag
);
    pcc_pkg::pcc_state_t st;
    pcc_pkg::pcc_state_t next_st;
    logic                rst_int_n;
    logic [7:0]          cis [`PCC_CIS_LEN];

    // ======================================================================
    // card information structure
    always_comb begin
        cis[0]  = 8'h01;
        cis[1]  = 8'h04;
        cis[2]  = 8'hdf;
        cis[3]  = 8'h4a;
        cis[4]  = 8'h01;
        cis[5]  = 8'hff;
        cis[6]  = 8'h1c;
        cis[7]  = 8'h04;
        cis[8]  = 8'h02;
        cis[9]  = 8'hd9;
        cis[10] = 8'h01;
        cis[11] = 8'hff;
        cis[12] = 8'h18;
        cis[13] = 8'h02;
        cis[14] = JEDEC_MAKER;
        cis[15] = JEDEC_DEVICE;
        cis[16] = 8'h20;
        cis[17] = 8'h04;
        cis[18] = MAKER_CODE[7:0];
        cis[19] = MAKER_CODE[15:8];
        cis[20] = PRODUCT_CODE[7:0];
        cis[21] = PRODUCT_CODE[15:8];
    end

    function automatic logic [7:0] cis_byte(input logic [10:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (!a[0] && a <= `PCC_CIS_TOP) begin
            v = cis[a[5:1]];
        end
        return v;
    endfunction : cis_byte

    assign rst_int_n = st.rst_sync[1];

    // ======================================================================
    // next state
    always_comb begin
        logic acc;
        logic rd_edge;
        logic wr_edge;
        logic [7:0] ccs;
        logic [7:0] rct;
        acc     = 1'b0;
        rd_edge = 1'b0;
        wr_edge = 1'b0;
        ccs     = 8'h00;
        rct     = 8'h00;
        next_st = st;
        next_st.rst_sync = {st.rst_sync[0], 1'b1};
        next_st.oe_s = {st.oe_s[1:0], oe_n};
        next_st.we_s = {st.we_s[1:0], we_n};
        acc = !reg_n && !ce1_n && !ide_mode;
        // strobe edges come from the second and third sync flops only,
        // so the first flop, which may still be settling, is never read
        rd_edge = st.oe_s[2] && !st.oe_s[1];
        wr_edge = st.we_s[2] && !st.we_s[1] && acc;
        next_st.irq_q = irq_int && !irq_dis;

        // power states
        next_st.idle_cnt = (core_busy || cmd_strobe) ? 12'h000
                         : (st.idle_cnt == 12'(IDLE_CYC)) ? st.idle_cnt
                         : st.idle_cnt + 12'h001;
        unique case (st.pwr)
            pcc_pkg::PCC_ACTIVE: begin
                if (st.pd_req || st.idle_cnt == 12'(IDLE_CYC)) begin
                    next_st.pwr = pcc_pkg::PCC_TO_SLEEP;
                    next_st.cnt = 12'h000;
                    next_st.auto_sleep = !st.pd_req;
                end
            end
            pcc_pkg::PCC_TO_SLEEP: begin
                next_st.cnt = st.cnt + 12'h001;
                if (st.cnt == 12'(`PCC_SLEEP_CYC - 1)) begin
                    next_st.pwr = pcc_pkg::PCC_SLEEP;
                end
            end
            pcc_pkg::PCC_SLEEP: begin
                if ((!st.pd_req && !st.auto_sleep) ||
                    (st.auto_sleep && cmd_strobe)) begin
                    next_st.pwr = pcc_pkg::PCC_TO_WAKE;
                    next_st.cnt = 12'h000;
                end
            end
            pcc_pkg::PCC_TO_WAKE: begin
                next_st.cnt = st.cnt + 12'h001;
                if (st.cnt == 12'(`PCC_SLEEP_CYC - 1)) begin
                    next_st.pwr = pcc_pkg::PCC_ACTIVE;
                    next_st.auto_sleep = 1'b0;
                    next_st.idle_cnt = 12'h000;
                end
            end
        endcase
        // sleep kept in its own flop so the pin needs no decode
        next_st.sleep = (next_st.pwr == pcc_pkg::PCC_SLEEP);
        // busy while moving between power states
        next_st.ready = !core_busy &&
                        (next_st.pwr == pcc_pkg::PCC_ACTIVE ||
                         next_st.pwr == pcc_pkg::PCC_SLEEP);
        next_st.ready_q = st.ready;

        // host writes
        if (wr_edge && addr == `PCC_ADDR_CCS) begin
            next_st.sig_en = wdata[`PCC_BIT_SIGEN];
            next_st.io8 = wdata[`PCC_BIT_IO8];
            next_st.pd_req = wdata[`PCC_BIT_PDREQ];
            if (wdata[`PCC_BIT_PDREQ] != st.pd_req) begin
                next_st.ready = 1'b0;
                if (!wdata[`PCC_BIT_PDREQ]) begin
                    next_st.auto_sleep = 1'b0;
                end
            end
        end
        if (wr_edge && addr == `PCC_ADDR_RCT) begin
            next_st.crl = wdata[`PCC_BIT_CRL];
            next_st.crl_mask = wdata[`PCC_BIT_RDY];
        end
        if (wr_edge && addr == `PCC_ADDR_CCN) begin
            next_st.drv = wdata[`PCC_BIT_DRV];
        end
        // ready change sets the latch, winning over a host write
        if (st.ready != st.ready_q && !st.crl_mask) begin
            next_st.crl = 1'b1;
        end

        // register reads
        ccs = 8'h00;
        ccs[`PCC_BIT_CHANGE_DETECTED_FLAG] = st.crl;
        ccs[`PCC_BIT_SIGEN] = st.sig_en;
        ccs[`PCC_BIT_IO8]   = st.io8;
        ccs[`PCC_BIT_PDREQ] = st.pd_req;
        ccs[`PCC_BIT_INTERRUPT_REQUEST_STATUS]  = st.irq_q;
        rct = `PCC_RCT_FIXED_ONES;
        rct[`PCC_BIT_CRL] = st.crl;
        rct[`PCC_BIT_RDY] = st.ready;
        next_st.rdata_oe = !reg_n && !ce1_n && !st.oe_s[1] && !ide_mode;
        if (rd_edge || !st.oe_s[1]) begin
            if (addr == `PCC_ADDR_CCS) begin
                next_st.rdata = ccs;
            end else if (addr == `PCC_ADDR_RCT) begin
                next_st.rdata = rct;
            end else if (addr == `PCC_ADDR_CCN) begin
                next_st.rdata = {3'b000, st.drv, 4'b0000};
            end else begin
                next_st.rdata = cis_byte(addr);
            end
        end
        next_st.stschg_n = !(st.crl && st.sig_en && io_mode);
    end

    // ======================================================================
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st          <= '0;
            st.oe_s     <= 3'b111;
            st.we_s     <= 3'b111;
            st.ready    <= 1'b1;
            st.ready_q  <= 1'b1;
            st.stschg_n <= 1'b1;
        end else if (ce) begin
            if (!rst_int_n) begin
                st          <= '0;
                st.rst_sync <= next_st.rst_sync;
                st.oe_s     <= 3'b111;
                st.we_s     <= 3'b111;
                st.ready    <= 1'b1;
                st.ready_q  <= 1'b1;
                st.stschg_n <= 1'b1;
            end else begin
                st <= next_st;
            end
        end
    end

    assign rdata    = st.rdata;
    assign rdata_oe = st.rdata_oe;
    assign stschg_n = st.stschg_n;
    assign ready    = st.ready;
    assign sleep    = st.sleep;
    assign eight_bit_host_flag = st.io8;

    // ======================================================================
    // checks
    property p_stschg;
        @(posedge clk) disable iff (!rst_int_n || !ce)
        !(st.crl && st.sig_en && io_mode) |=> stschg_n;
    endproperty
    a_stschg: assert property (p_stschg) else $error("stschg low");

    property p_stschg_low;
        @(posedge clk) disable iff (!rst_int_n || !ce)
        (st.crl && st.sig_en && io_mode) |=> !stschg_n;
    endproperty
    a_stschg_low: assert property (p_stschg_low) else $error("stschg");

    property p_busy;
        @(posedge clk) disable iff (!rst_int_n || !ce)
        (st.pwr == pcc_pkg::PCC_TO_SLEEP) |-> !ready;
    endproperty
    a_busy: assert property (p_busy) else $error("ready in transit");

    property p_sleep;
        @(posedge clk) disable iff (!rst_int_n || !ce)
        (st.pwr == pcc_pkg::PCC_ACTIVE && st.pd_req) |=> ##[0:30] sleep;
    endproperty
    a_sleep: assert property (p_sleep) else $error("no sleep");

    property p_crl;
        @(posedge clk) disable iff (!rst_int_n || !ce)
        ($changed(st.ready) && !st.crl_mask) |=> st.crl;
    endproperty
    a_crl: assert property (p_crl) else $error("latch not set");

    property p_irq;
        @(posedge clk) disable iff (!rst_int_n || !ce)
        irq_dis |=> !st.irq_q;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt_request_status shown");

    property p_irq_set;
        @(posedge clk) disable iff (!rst_int_n || !ce)
        (irq_int && !irq_dis) |=> st.irq_q;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("interrupt_request_status lost");

    property p_ide;
        @(posedge clk) disable iff (!rst_int_n || !ce)
        ide_mode |=> !rdata_oe;
    endproperty
    a_ide: assert property (p_ide) else $error("ide access");

    // automatic power-down must leave on the first command
    property p_wake;
        @(posedge clk) disable iff (!rst_int_n || !ce)
        (st.pwr == pcc_pkg::PCC_SLEEP && st.auto_sleep && cmd_strobe)
            |=> (st.pwr == pcc_pkg::PCC_TO_WAKE);
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
endmodule : pcc_config_status
`default_nettype wire

// file: dv/pcc_host_model.sv
// host socket controller model driving attribute memory cycles
`timescale 1ns/1ps
`default_nettype none
module pcc_host_model (
    input  wire logic        clk,   // bench clock
    input  wire logic [7:0]  rdata, // card read data
    output logic             reg_n, // attribute select, active low
    output logic             ce1_n, // even byte select, active low
    output logic             oe_n,  // read strobe, active low
    output logic             we_n,  // write strobe, active low
    output logic [10:0]      addr,  // byte address
    output logic [7:0]       wdata  // write data
);
    initial begin
        {reg_n, ce1_n, oe_n, we_n} = 4'hf;
        addr = 11'h000;
        wdata = 8'h00;
    end
    // strobe 6 cycles low, 6 high: covers the three-flop sync spacing
    task automatic cyc(input logic [10:0] a, input logic [7:0] d,
                       input logic rd, output logic [7:0] q);
        @(posedge clk);
        addr <= a & 11'h07fe;
        wdata <= d;
        reg_n <= 1'b0;
        ce1_n <= 1'b0;
        oe_n <= !rd;
        we_n <= rd;
        repeat (6) @(posedge clk);
        q = rdata;
        {reg_n, ce1_n, oe_n, we_n} <= 4'hf;
        // released bus shows the inverse, not the last value
        addr <= ~a;
        wdata <= ~d;
        repeat (6) @(posedge clk);
    endtask : cyc
endmodule : pcc_host_model
`default_nettype wire

// file: dv/pcc_config_status_bench.sv
// self-checking bench for the card configuration and status bank
`timescale 1ns/1ps
`default_nettype none
`include "pcc_regs.svh"
module pcc_config_status_bench;
    localparam logic [7:0]  JM = 8'h96;     // arbitrary value
    localparam logic [7:0]  JD = 8'h69;     // arbitrary value
    localparam logic [15:0] MC = 16'h1a2b;  // arbitrary value
    localparam logic [15:0] PC = 16'h3c4d;  // arbitrary value
    logic        clk, rst_n, ce, ide_mode, io_mode, irq_int, irq_dis;
    logic        cmd_strobe, core_busy, reg_n, ce1_n, oe_n, we_n, awake;
    logic        rdata_oe, stschg_n, ready, sleep, eight_bit_host_flag;
    logic [10:0] addr;
    logic [7:0]  wdata, rdata, q, w;
    int          bad_count, comparisons, cycles;

    pcc_host_model host (.clk(clk), .rdata(rdata), .reg_n(reg_n),
        .ce1_n(ce1_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .wdata(wdata));
    pcc_config_status #(.JEDEC_MAKER(JM), .JEDEC_DEVICE(JD),
        .MAKER_CODE(MC), .PRODUCT_CODE(PC), .IDLE_CYC(100)) DUT (
        .clk(clk), .rst_n(rst_n), .ce(ce), .reg_n(reg_n), .ce1_n(ce1_n),
        .oe_n(oe_n), .we_n(we_n), .addr(addr), .wdata(wdata),
        .ide_mode(ide_mode), .io_mode(io_mode), .irq_int(irq_int),
        .irq_dis(irq_dis), .cmd_strobe(cmd_strobe), .core_busy(core_busy),
        .rdata(rdata), .rdata_oe(rdata_oe), .stschg_n(stschg_n),
        .ready(ready), .sleep(sleep),
        .eight_bit_host_flag(eight_bit_host_flag));

    function automatic logic [7:0] cis_exp(input int i);
        logic [7:0] t [22];
        t = '{8'h01, 8'h04, 8'hdf, 8'h4a, 8'h01, 8'hff, 8'h1c, 8'h04,
              8'h02, 8'hd9, 8'h01, 8'hff, 8'h18, 8'h02, JM, JD, 8'h20,
              8'h04, MC[7:0], MC[15:8], PC[7:0], PC[15:8]};
        return (i < 22) ? t[i] : 8'h00;
    endfunction : cis_exp
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : check
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        logic [7:0] x;
        host.cyc(a, d, 1'b0, x);
    endtask : wr
    task automatic rd(input logic [10:0] a);
        host.cyc(a, 8'h00, 1'b1, q);
    endtask : rd
    task automatic wait_sleep(input logic v);
        for (int i = 0; i < 100 && sleep !== v; i++) @(posedge clk);
    endtask : wait_sleep
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // periodic commands keep the card out of automatic power-down
    always @(posedge clk) begin
        cycles <= cycles + 1;
        cmd_strobe <= awake && (cycles % 40 == 0);
        if (cycles > 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    initial begin
        {rst_n, ide_mode, io_mode, irq_int, irq_dis} = 5'h00;
        {cmd_strobe, core_busy, awake} = 3'h0;
        ce = 1'b1;
        bad_count = 0;
        comparisons = 0;
        cycles = 0;
        void'($urandom(43833));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        awake <= 1'b1;
        repeat (4) @(posedge clk);
        rd(`PCC_ADDR_CCS); check(q, `PCC_CCS_RESET);
        rd(`PCC_ADDR_RCT); check(q & 8'hdd, `PCC_RCT_RESET);
        check(q[1], ready);
        rd(`PCC_ADDR_CCN); check(q, `PCC_CCN_RESET);
        $display("test reset done");
        io_mode <= 1'b1;
        wr(`PCC_ADDR_CCS, 8'h40); check(stschg_n, 1);
        wr(`PCC_ADDR_RCT, 8'hff); check(stschg_n, 0);
        rd(`PCC_ADDR_RCT); check(q & 8'hfd, 8'h2c);
        rd(`PCC_ADDR_CCS); check(q[7], 1);
        io_mode <= 1'b0;
        repeat (4) @(posedge clk); check(stschg_n, 1);
        io_mode <= 1'b1;
        wr(`PCC_ADDR_CCS, 8'h00); check(stschg_n, 1);
        wr(`PCC_ADDR_RCT, 8'h00);
        rd(`PCC_ADDR_CCS); check(q[7], 0);
        $display("test status change done");
        for (int i = 0; i < 6; i++) begin
            w = (i == 0) ? 8'hfb : 8'($urandom) & 8'hfb;
            wr(`PCC_ADDR_CCS, w);
            rd(`PCC_ADDR_CCS); check(q, w & 8'h60);
            check(eight_bit_host_flag, w[5]);
            w = (i == 0) ? 8'hef : 8'($urandom);
            wr(`PCC_ADDR_CCN, w);
            rd(`PCC_ADDR_CCN); check(q, w & 8'h10);
        end
        $display("test readback done");
        awake <= 1'b0;
        wr(`PCC_ADDR_CCS, 8'h04); check(ready, 0);
        wait_sleep(1); check({sleep, ready}, 3);
        rd(`PCC_ADDR_RCT); check(q[5], 1);
        wr(`PCC_ADDR_CCS, 8'h00); check(ready, 0);
        wait_sleep(0);
        repeat (`PCC_SLEEP_CYC) @(posedge clk);
        check({sleep, ready}, 1);
        repeat (300) @(posedge clk); check(sleep, 1);
        awake <= 1'b1;
        repeat (80) @(posedge clk); check(sleep, 0);
        $display("test power done");
        irq_int <= 1'b1;
        rd(`PCC_ADDR_CCS); check(q[1], 1);
        io_mode <= 1'b0;
        rd(`PCC_ADDR_CCS); check(q[1], 1);
        irq_dis <= 1'b1;
        rd(`PCC_ADDR_CCS); check(q[1], 0);
        {irq_int, irq_dis} <= 2'b00;
        $display("test interrupt done");
        for (int i = 0; i < 23; i++) begin
            rd(11'(2 * i)); check(q, cis_exp(i));
        end
        $display("test information structure done");
        wr(`PCC_ADDR_CCN, 8'h10);
        ide_mode <= 1'b1;
        wr(`PCC_ADDR_CCN, 8'h00); check(rdata_oe, 0);
        ide_mode <= 1'b0;
        rd(`PCC_ADDR_CCN); check(q, 8'h10);
        $display("test ide refusal done");
        ce <= 1'b0;
        wr(`PCC_ADDR_CCN, 8'h00);
        ce <= 1'b1;
        rd(`PCC_ADDR_CCN); check(q, 8'h10);
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(`PCC_ADDR_CCN); check(q, `PCC_CCN_RESET);
        rd(`PCC_ADDR_CCS); check(q, `PCC_CCS_RESET);
        $display("test freeze and reset done");
        end_of_test();
    end
endmodule : pcc_config_status_bench
`default_nettype wire
